/* File: verilog/ctp_defines.svh */
// Purpose: constants for the timer prescaler block
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes: offsets are byte addresses
`ifndef CTP_DEFINES_SVH
`define CTP_DEFINES_SVH
`define CTP_OFF_CTRL 12'h000
`define CTP_OFF_PRD_LO 12'h004
`define CTP_OFF_PRD_HI 12'h008
`define CTP_OFF_CNT_LO 12'h00C
`define CTP_OFF_CNT_HI 12'h010
`define CTP_OFF_PSC_LO 12'h014
`define CTP_OFF_PSC_HI 12'h018
`define CTP_BIT_RELOAD 5
`define CTP_BIT_STOP 4
`define CTP_PRD_RESET 32'hFFFFFFFF
`define CTP_PRD_LO_RESET 16'hFFFF
`define CTP_PRD_HI_RESET 16'h0000
`define CTP_DDR_RESET 8'h00
`define CTP_PSC_RESET 8'h00
`define CTP_RESP_OKAY 2'b00
`define CTP_RESP_SLVERR 2'b10
`endif

/* File: verilog/ctp_pkg.sv */
// Purpose: shared types of the timer prescaler block
// Assumes: nothing
// Notes: none
package ctp_pkg;
    typedef logic [15:0] ctp_half_t;
    typedef logic [31:0] ctp_word_t;
endpackage

/* File: verilog/ctp_prescaler.sv */
// Purpose: prescale counter with reload from divide-down value
// Assumes: reload_strobe is a one-cycle pulse on aclk
// Notes: tick marks the cycle the main counter steps
`timescale 1ns/1ps
`include "ctp_defines.svh"
`default_nettype none
module ctp_prescaler #(
    parameter int WIDTH = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic reload_strobe,
    input wire logic [WIDTH-1:0] divide_down,
    output logic [WIDTH-1:0] prescale_count,
    output logic tick
);
    logic [WIDTH-1:0] psc_reg;
    logic [WIDTH-1:0] psc_next;

    always_comb begin
        psc_next = psc_reg;
        tick = 1'b0;
        if (reload_strobe) begin
            psc_next = divide_down;
        end else if (run) begin
            if (psc_reg != '0) begin
                psc_next = psc_reg - WIDTH'(1);
            end else begin
                psc_next = divide_down;
                tick = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            psc_reg <= '0;
        end else begin
            psc_reg <= psc_next;
        end
    end

    assign prescale_count = psc_reg;

    property p_zero_tick;
        @(posedge aclk) disable iff (!aresetn)
        (run && !reload_strobe && psc_reg == '0) |-> tick ##1
        (psc_reg == $past(divide_down));
    endproperty
    a_zero_tick: assert property (p_zero_tick)
        else $error("no reload at zero");

    property p_dec;
        @(posedge aclk) disable iff (!aresetn)
        (run && !reload_strobe && psc_reg != '0) |=> (psc_reg ==
        $past(psc_reg) - WIDTH'(1));
    endproperty
    a_dec: assert property (p_dec)
        else $error("prescale not decremented");

    property p_reload;
        @(posedge aclk) disable iff (!aresetn)
        reload_strobe |=> psc_reg == $past(divide_down);
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload missed");

    property p_tick_only_zero;
        @(posedge aclk) disable iff (!aresetn)
        tick |-> (psc_reg == '0 && run);
    endproperty
    a_tick_only_zero: assert property (p_tick_only_zero)
        else $error("tick off zero");
endmodule
`default_nettype wire

/* File: verilog/ctp_timer.sv */
// Purpose: 32-bit down timer with 16-bit prescaler, AXI4-Lite slave
// Assumes: single clock, synchronous active-low reset
// Notes: one write and one read in flight at a time
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ctp_defines.svh"
`default_nettype none
// Functional notes
// - main counter steps every divide plus one
// - divide-down low/high bytes, read-write, reset zero
// - prescale counts down while above zero
// - at zero reload prescale, step main
// - reload bit reloads prescale counter
// - prescale count readable, writes ignored
// - prescale count zero after reset
// - reload loads main and prescale, reads zero
// - main reloads period after reaching zero
// - stop bit halts, clear at reset
module ctp_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic main_tick,
    output logic main_zero
);
    import ctp_pkg::*;

    ////////////////////////////////////////////////////////////////////
    logic [11:0] awa_reg, awa_next;
    logic awh_reg, awh_next;
    logic [31:0] wd_reg, wd_next;
    logic [3:0] ws_reg, ws_next;
    logic wh_reg, wh_next;
    logic bv_reg, bv_next;
    logic [1:0] br_reg, br_next;
    logic rv_reg, rv_next;
    logic [1:0] rr_reg, rr_next;
    ctp_word_t rd_reg, rd_next;
    logic stop_control_reg, stop_control_next;
    logic [7:0] divide_down_low_reg, divide_down_low_next;
    logic [7:0] divide_down_high_reg, divide_down_high_next;
    ctp_half_t period_low_reg, period_low_next;
    ctp_half_t period_high_reg, period_high_next;
    ctp_word_t cnt_reg, cnt_next;
    logic zero_reg, zero_next;
    logic reload_strobe;
    logic do_wr;
    logic presc_tick;
    ctp_half_t prescale_count;
    logic [7:0] prescale_count_low, prescale_count_high;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = old;
        if (s[0]) merge16[7:0] = d[7:0];
        if (s[1]) merge16[15:8] = d[15:8];
    endfunction

    assign do_wr = awh_reg && wh_reg && !bv_reg;
    assign s_axi_awready = !awh_reg && !bv_reg;
    assign s_axi_wready = !wh_reg && !bv_reg;
    assign reload_strobe = do_wr && {awa_reg[11:2], 2'b00} == `CTP_OFF_CTRL
        && ws_reg[0] && wd_reg[`CTP_BIT_RELOAD];
    assign prescale_count_low = prescale_count[7:0];
    assign prescale_count_high = prescale_count[15:8];

    ////////////////////////////////////////////////////////////////////
    ctp_prescaler #(
        .WIDTH(16)
    ) u_presc (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(!stop_control_reg),
        .reload_strobe(reload_strobe),
        .divide_down({divide_down_high_reg, divide_down_low_reg}),
        .prescale_count(prescale_count),
        .tick(presc_tick)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        awa_next = awa_reg;
        awh_next = awh_reg;
        wd_next = wd_reg;
        ws_next = ws_reg;
        wh_next = wh_reg;
        bv_next = bv_reg;
        br_next = br_reg;
        stop_control_next = stop_control_reg;
        divide_down_low_next = divide_down_low_reg;
        divide_down_high_next = divide_down_high_reg;
        period_low_next = period_low_reg;
        period_high_next = period_high_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            awa_next = s_axi_awaddr;
            awh_next = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb;
            wh_next = 1'b1;
        end
        if (bv_reg && s_axi_bready) begin
            bv_next = 1'b0;
        end
        if (do_wr) begin
            awh_next = 1'b0;
            wh_next = 1'b0;
            bv_next = 1'b1;
            br_next = `CTP_RESP_OKAY;
            case ({awa_reg[11:2], 2'b00})
                `CTP_OFF_CTRL: begin
                    if (ws_reg[0]) begin
                        stop_control_next = wd_reg[`CTP_BIT_STOP];
                    end
                end
                `CTP_OFF_PRD_LO: period_low_next =
                    merge16(period_low_reg, wd_reg, ws_reg);
                `CTP_OFF_PRD_HI: period_high_next =
                    merge16(period_high_reg, wd_reg, ws_reg);
                `CTP_OFF_CNT_LO, `CTP_OFF_CNT_HI: begin
                end
                `CTP_OFF_PSC_LO: begin
                    if (ws_reg[0]) begin
                        divide_down_low_next = wd_reg[7:0];
                    end
                end
                `CTP_OFF_PSC_HI: begin
                    if (ws_reg[0]) begin
                        divide_down_high_next = wd_reg[7:0];
                    end
                end
                default: br_next = `CTP_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awa_reg <= 12'h000;
            awh_reg <= 1'b0;
            wd_reg <= 32'h00000000;
            ws_reg <= 4'h0;
            wh_reg <= 1'b0;
            bv_reg <= 1'b0;
            br_reg <= 2'h0;
            stop_control_reg <= 1'b0;
            divide_down_low_reg <= `CTP_DDR_RESET;
            divide_down_high_reg <= `CTP_DDR_RESET;
            period_low_reg <= `CTP_PRD_LO_RESET;
            period_high_reg <= `CTP_PRD_HI_RESET;
        end else begin
            awa_reg <= awa_next;
            awh_reg <= awh_next;
            wd_reg <= wd_next;
            ws_reg <= ws_next;
            wh_reg <= wh_next;
            bv_reg <= bv_next;
            br_reg <= br_next;
            stop_control_reg <= stop_control_next;
            divide_down_low_reg <= divide_down_low_next;
            divide_down_high_reg <= divide_down_high_next;
            period_low_reg <= period_low_next;
            period_high_reg <= period_high_next;
        end
    end

    assign s_axi_bvalid = bv_reg;
    assign s_axi_bresp = br_reg;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        rv_next = rv_reg;
        rr_next = rr_reg;
        rd_next = rd_reg;
        if (rv_reg && s_axi_rready) begin
            rv_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rv_next = 1'b1;
            rr_next = `CTP_RESP_OKAY;
            rd_next = 32'h00000000;
            case ({s_axi_araddr[11:2], 2'b00})
                `CTP_OFF_CTRL: rd_next[`CTP_BIT_STOP] =
                    stop_control_reg;
                `CTP_OFF_PRD_LO: rd_next[15:0] = period_low_reg;
                `CTP_OFF_PRD_HI: rd_next[15:0] = period_high_reg;
                `CTP_OFF_CNT_LO: rd_next[15:0] = cnt_reg[15:0];
                `CTP_OFF_CNT_HI: rd_next[15:0] = cnt_reg[31:16];
                `CTP_OFF_PSC_LO: rd_next[15:0] =
                    {prescale_count_low, divide_down_low_reg};
                `CTP_OFF_PSC_HI: rd_next[15:0] =
                    {prescale_count_high, divide_down_high_reg};
                default: rr_next = `CTP_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rv_reg <= 1'b0;
            rr_reg <= 2'h0;
            rd_reg <= 32'h00000000;
        end else begin
            rv_reg <= rv_next;
            rr_reg <= rr_next;
            rd_reg <= rd_next;
        end
    end

    assign s_axi_arready = !rv_reg;
    assign s_axi_rvalid = rv_reg;
    assign s_axi_rresp = rr_reg;
    assign s_axi_rdata = rd_reg;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        cnt_next = cnt_reg;
        if (reload_strobe) begin
            cnt_next = {period_high_reg, period_low_reg};
        end else if (presc_tick) begin
            if (cnt_reg == 32'h00000000) begin
                cnt_next = {period_high_reg, period_low_reg};
            end else begin
                cnt_next = cnt_reg - 32'h00000001;
            end
        end
        zero_next = cnt_next == 32'h00000000;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= `CTP_PRD_RESET;
            zero_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            zero_reg <= zero_next;
        end
    end

    assign main_tick = presc_tick;
    // registered copy of counter-at-zero, same timing as the counter
    assign main_zero = zero_reg;

    property p_main_dec;
        @(posedge aclk) disable iff (!aresetn)
        (presc_tick && !reload_strobe && cnt_reg != 32'h00000000) |=>
        cnt_reg == $past(cnt_reg) - 32'h00000001;
    endproperty
    a_main_dec: assert property (p_main_dec)
        else $error("main counter not stepped");

    property p_main_reload;
        @(posedge aclk) disable iff (!aresetn)
        (presc_tick && !reload_strobe && cnt_reg == 32'h00000000) |=>
        cnt_reg == {$past(period_high_reg), $past(period_low_reg)};
    endproperty
    a_main_reload: assert property (p_main_reload)
        else $error("main counter not reloaded");

    property p_trb;
        @(posedge aclk) disable iff (!aresetn)
        reload_strobe |=> cnt_reg == {$past(period_high_reg),
        $past(period_low_reg)};
    endproperty
    a_trb: assert property (p_trb)
        else $error("reload bit ignored");

    property p_stop;
        @(posedge aclk) disable iff (!aresetn)
        (stop_control_reg && !reload_strobe) |=> $stable(cnt_reg);
    endproperty
    a_stop: assert property (p_stop)
        else $error("timer ran while stopped");
endmodule
`default_nettype wire

/* File: dv/ctp_testbench.sv */
// Purpose: self-checking bench for the timer prescaler
// Assumes: register map and bus timing of ctp_timer
// Notes: random divide-down and period values, fixed seed
`timescale 1ns/1ps
`include "ctp_defines.svh"
`default_nettype none
module testbench;
    import ctp_pkg::*;
    localparam ctp_word_t STOP = 32'h1 << `CTP_BIT_STOP;
    localparam ctp_word_t RLD = 32'h1 << `CTP_BIT_RELOAD;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    ctp_word_t s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b1;
    logic [11:0] s_axi_araddr = 12'h000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    ctp_word_t s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b1;
    logic main_tick;
    logic main_zero;
    int num_errors = 0;
    int compares = 0;
    integer seed = 32'h7cc5ce99;
    ctp_word_t d;
    ctp_word_t t;
    ctp_word_t z;
    logic [1:0] r;
    logic [7:0] dl;
    logic [7:0] dh;
    ctp_half_t p;
    logic [11:0] ra [4] = '{`CTP_OFF_PSC_LO, `CTP_OFF_PSC_HI,
        `CTP_OFF_PRD_LO, `CTP_OFF_PRD_HI};
    ctp_word_t re [4] = '{32'h0, 32'h0, 32'h0000FFFF, 32'h0};

    always #20 aclk = ~aclk;

    ctp_timer i_ctp_timer (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .main_tick(main_tick),
        .main_zero(main_zero));

    ////////////////////////////////////////////////////////////////////
    function automatic ctp_word_t psc_word(input logic [7:0] v);
        return {16'h0, v, v};
    endfunction

    task automatic chk(input string nm, input ctp_word_t e,
                       input ctp_word_t g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_of_test;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input ctp_word_t v,
                      input logic [1:0] er);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        chk("bresp", 32'(er), 32'(s_axi_bresp));
    endtask

    task automatic rd(input logic [11:0] a, output ctp_word_t v,
                      output logic [1:0] rr);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        rr = s_axi_rresp;
    endtask

    // counts step pulses and cycles at zero over a window
    task automatic watch(input int n, output ctp_word_t tk,
                         output ctp_word_t zc);
        tk = 32'h0;
        zc = 32'h0;
        repeat (n) begin
            @(posedge aclk);
            if (main_tick === 1'b1) tk++;
            if (main_zero === 1'b1) zc++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
            rd(ra[i], d, r);
            chk("reset_value", re[i], d);
        end
        wr(12'h01C, 32'h1, `CTP_RESP_SLVERR);
        rd(12'h01C, d, r);
        chk("unmapped_resp", 32'(`CTP_RESP_SLVERR), 32'(r));
        chk("unmapped_data", 32'h0, d);
        wr(`CTP_OFF_CTRL, STOP, `CTP_RESP_OKAY);
        watch(20, t, z);
        chk("ticks_stopped", 32'h0, t);
        for (int i = 0; i < 4; i++) begin
            dl = (i == 0) ? 8'hFF : 8'($random(seed));
            dh = (i == 0) ? 8'hFF : 8'($random(seed));
            wr(`CTP_OFF_PSC_LO, {16'h0, 8'hA5, dl}, `CTP_RESP_OKAY);
            wr(`CTP_OFF_PSC_HI, {16'h0, 8'h5A, dh}, `CTP_RESP_OKAY);
            s_axi_wstrb <= 4'h2;
            wr(`CTP_OFF_PSC_LO, 32'h0000FFFF, `CTP_RESP_OKAY);
            s_axi_wstrb <= 4'hF;
            wr(`CTP_OFF_CTRL, STOP | RLD, `CTP_RESP_OKAY);
            rd(`CTP_OFF_PSC_LO, d, r);
            chk("prescale_low", psc_word(dl), d);
            rd(`CTP_OFF_PSC_HI, d, r);
            chk("prescale_high", psc_word(dh), d);
            rd(`CTP_OFF_CTRL, d, r);
            chk("ctrl", STOP, d);
            rd(`CTP_OFF_CNT_LO, d, r);
            chk("counter_low", 32'h0000FFFF, d);
        end
        for (int i = 0; i < 5; i++) begin
            dl = (i == 0) ? 8'h00 : 8'($random(seed)) & 8'h07;
            p = 16'(1 + (($random(seed)) & 3));
            wr(`CTP_OFF_PSC_LO, {24'h0, dl}, `CTP_RESP_OKAY);
            wr(`CTP_OFF_PSC_HI, 32'h0, `CTP_RESP_OKAY);
            wr(`CTP_OFF_PRD_LO, {16'h0, p}, `CTP_RESP_OKAY);
            wr(`CTP_OFF_PRD_HI, 32'h0, `CTP_RESP_OKAY);
            wr(`CTP_OFF_CTRL, STOP | RLD, `CTP_RESP_OKAY);
            rd(`CTP_OFF_CNT_LO, d, r);
            chk("counter_reload", {16'h0, p}, d);
            wr(`CTP_OFF_CTRL, 32'h0, `CTP_RESP_OKAY);
            watch(4 * (dl + 1) * (p + 1), t, z);
            chk("tick_count", 32'(4 * (p + 1)), t);
            chk("zero_cycles", 32'(4 * (dl + 1)), z);
            wr(`CTP_OFF_CTRL, STOP, `CTP_RESP_OKAY);
        end
        end_of_test;
    end

    initial begin
        #800000;
        num_errors++;
        end_of_test;
    end
endmodule
`default_nettype wire
